/* File: bench/testbench.sv */
`timescale 1ns/10ps
// Drives guest events, reads exit records as the hypervisor would, and checks them
module testbench;
    logic clock;
    logic sys_rst;
    vie_pkg::vie_ipi_req_type ipiReq;
    vie_pkg::vie_acc_req_type accReq;
    logic wbCyc;
    logic wbStb;
    logic wbWe;
    logic [7:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatW;
    logic [31:0] wbDatR;
    logic wbAck;
    logic irq;
    logic exitEvent;
    vie_pkg::vie_exit_record_type exitRecord;
    logic [1:0] curMask;
    int mismatches;
    int checked;

    vie_exit_reporter i_vie_exit_reporter (
        .clock(clock), .sys_rst(sys_rst), .ipiReq(ipiReq), .accReq(accReq),
        .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
        .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
        .irq(irq), .exitEvent(exitEvent), .exitRecord(exitRecord)
    );

    vie_hv_model i_vie_hv_model (
        .clock(clock), .wbDatR(wbDatR), .wbAck(wbAck), .wbCyc(wbCyc), .wbStb(wbStb),
        .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW)
    );

    // 25 MHz core clock
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Counts, verdict and end of run
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Compare one value and log any difference
    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t %s: got %h, expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] unused;
        i_vie_hv_model.bus_cycle(1'b1, adr, sel, dat, unused);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input string what);
        logic [31:0] got;
        i_vie_hv_model.bus_cycle(1'b0, adr, 4'hF, 32'h0, got);
        check({32'h0, got}, {32'h0, exp}, what);
    endtask

    // IPI attempt from flags {level, unsupported, bcast, logical, logOk, physOk, backOk, onCore}
    function automatic vie_pkg::vie_ipi_req_type mk(input logic [7:0] f, input logic [7:0] cl,
        input logic [9:0] tg);
        vie_pkg::vie_ipi_req_type r;
        r = '{1'b1, {24'hA5C3E1, cl}, {22'h0F0F0F, tg}, f[7], f[6], f[5], f[4], cl, tg,
            f[3], f[2], f[1], f[0], 8'h15, 8'h2A};
        return r;
    endfunction

    // Launch requests for one cycle; pulse one edge later, lasting one cycle
    task automatic fire(input vie_pkg::vie_ipi_req_type ir, input vie_pkg::vie_acc_req_type ar,
        input logic expEvent);
        @(posedge clock);
        ipiReq <= ir;
        accReq <= ar;
        @(posedge clock);
        ipiReq.valid <= 1'b0;
        accReq.valid <= 1'b0;
        #1;
        check({63'h0, exitEvent}, {63'h0, expEvent}, "exit pulse");
        @(posedge clock);
        #1;
        check({63'h0, exitEvent}, 64'h0, "pulse width");
    endtask

    // Record on the port and through the registers
    task automatic chk_rec(input logic [31:0] code, input logic [63:0] first,
        input logic [63:0] second, input logic withSecond);
        check({32'h0, exitRecord.code}, {32'h0, code}, "exit code");
        check(exitRecord.first, first, "first detail");
        rd(vie_pkg::REG_EXIT_CODE, code, "exit code reg");
        rd(vie_pkg::REG_FIRST_LO, first[31:0], "first lo");
        rd(vie_pkg::REG_FIRST_HI, first[63:32], "first hi");
        if (withSecond)
        begin
            check(exitRecord.second, second, "second detail");
            rd(vie_pkg::REG_SECOND_LO, second[31:0], "second lo");
            rd(vie_pkg::REG_SECOND_HI, second[63:32], "second hi");
        end
    endtask

    // Sticky status: irq follows the mask, a written one clears
    task automatic sts(input logic [1:0] bits);
        rd(vie_pkg::REG_STATUS, {30'h0, bits}, "status set");
        check({63'h0, irq}, {63'h0, |(bits & curMask)}, "irq level");
        wr(vie_pkg::REG_STATUS, {30'h0, bits}, 4'h1);
        repeat (2) @(posedge clock);
        #1;
        check({63'h0, irq}, 64'h0, "irq after clear");
        rd(vie_pkg::REG_STATUS, 32'h0, "status clear");
    endtask

    task automatic run_ipi(input logic [7:0] f, input logic [7:0] cl, input logic [9:0] tg,
        input logic fail, input logic [31:0] cause, input logic [7:0] idx);
        vie_pkg::vie_ipi_req_type r;
        r = mk(f, cl, tg);
        fire(r, '0, fail);
        if (fail)
        begin
            chk_rec(vie_pkg::IPI_INCOMPLETE_EXIT_CODE, {r.cmdHigh, r.cmdLow},
                {cause, 24'h0, idx}, 1'b1);
            sts(2'h1);
        end
    endtask

    // Second word is only defined for a completion write
    task automatic run_acc(input logic w, input logic [11:0] off, input logic acc,
        input logic lvl, input logic [7:0] vec, input logic fail, input logic withSecond);
        fire('0, '{1'b1, w, off, acc, lvl, vec}, fail);
        if (fail)
        begin
            chk_rec(vie_pkg::UNACCELERATED_ACCESS_EXIT_CODE, {31'h0, w, 20'h0, off[11:4], 4'h0},
                {56'h0, vec}, withSecond);
            sts(2'h2);
        end
    endtask

    // Hang guard, generous against the well under a thousand cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clock);
        mismatches++;
        stop_test();
    end

    initial
    begin
        mismatches = 0;
        checked = 0;
        curMask = 2'h0;
        ipiReq = '0;
        accReq = '0;
        sys_rst = 1'b1;
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        // Reset values, read-only record, unmapped place
        rd(vie_pkg::REG_STATUS, 32'h0, "status reset");
        rd(vie_pkg::REG_MASK, 32'h0, "mask reset");
        rd(vie_pkg::REG_CONTROL, 32'h1, "control reset");
        wr(vie_pkg::REG_FIRST_LO, 32'hFFFFFFFF, 4'hF);
        rd(vie_pkg::REG_FIRST_LO, 32'h0, "record read only");
        wr(8'h20, 32'hFFFFFFFF, 4'hF);
        rd(8'h20, 32'h0, "unmapped");
        // Every failure cause, boundaries and index source; mask clear
        run_ipi(8'h8F, 8'h01, 10'h001, 1'b1, vie_pkg::CAUSE_BAD_TYPE, 8'h00);
        run_ipi(8'h4F, 8'h01, 10'h001, 1'b1, vie_pkg::CAUSE_BAD_TYPE, 8'h00);
        run_ipi(8'h0E, 8'h01, 10'h003, 1'b1, vie_pkg::CAUSE_NOT_RUNNING, 8'h2A);
        run_ipi(8'h1E, 8'h02, 10'h003, 1'b1, vie_pkg::CAUSE_NOT_RUNNING, 8'h15);
        run_ipi(8'h1F, 8'h41, 10'h003, 1'b1, vie_pkg::CAUSE_BAD_TARGET, 8'h15);
        run_ipi(8'h1F, 8'h40, 10'h003, 1'b0, 32'h0, 8'h00);
        run_ipi(8'h0F, 8'h01, 10'h201, 1'b1, vie_pkg::CAUSE_BAD_TARGET, 8'h2A);
        run_ipi(8'h0F, 8'h01, 10'h200, 1'b0, 32'h0, 8'h00);
        run_ipi(8'h0B, 8'h01, 10'h004, 1'b1, vie_pkg::CAUSE_BAD_TARGET, 8'h2A);
        run_ipi(8'h17, 8'h03, 10'h004, 1'b1, vie_pkg::CAUSE_BAD_TARGET, 8'h15);
        run_ipi(8'h3D, 8'h03, 10'h005, 1'b1, vie_pkg::CAUSE_BAD_BACKING, 8'h2A);
        run_ipi(8'h1D, 8'h03, 10'h005, 1'b1, vie_pkg::CAUSE_BAD_BACKING, 8'h15);
        run_ipi(8'h2B, 8'h01, 10'h005, 1'b0, 32'h0, 8'h00);
        // Guest register accesses
        run_acc(1'b0, 12'h3A5, 1'b0, 1'b0, 8'h00, 1'b1, 1'b0);
        run_acc(1'b1, 12'h3F0, 1'b0, 1'b0, 8'h00, 1'b1, 1'b0);
        run_acc(1'b1, 12'h080, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
        run_acc(1'b1, 12'h0B0, 1'b1, 1'b1, 8'h5C, 1'b1, 1'b1);
        run_acc(1'b1, 12'h0B0, 1'b1, 1'b0, 8'h5C, 1'b0, 1'b0);
        // Unmasked interrupt; a write with byte lane 0 off leaves the mask alone
        curMask = 2'h3;
        wr(vie_pkg::REG_MASK, 32'h3, 4'h1);
        wr(vie_pkg::REG_MASK, 32'h0, 4'h0);
        rd(vie_pkg::REG_MASK, 32'h3, "mask kept");
        run_ipi(8'h0E, 8'h07, 10'h007, 1'b1, vie_pkg::CAUSE_NOT_RUNNING, 8'h2A);
        run_acc(1'b0, 12'h300, 1'b0, 1'b0, 8'h00, 1'b1, 1'b0);
        // Both exits in one cycle: one whole record, the access is dropped
        fire(mk(8'h0E, 8'h01, 10'h001), '{1'b1, 1'b0, 12'h3A0, 1'b0, 1'b0, 8'h00}, 1'b1);
        chk_rec(vie_pkg::IPI_INCOMPLETE_EXIT_CODE, {24'hA5C3E1, 8'h01, 22'h0F0F0F, 10'h001},
            {vie_pkg::CAUSE_NOT_RUNNING, 32'h2A}, 1'b1);
        sts(2'h1);
        // Back to back: the later record replaces the earlier one
        @(posedge clock);
        ipiReq <= mk(8'h0E, 8'h02, 10'h002);
        @(posedge clock);
        ipiReq.valid <= 1'b0;
        accReq <= '{1'b1, 1'b1, 12'h3F0, 1'b0, 1'b0, 8'h00};
        #1;
        check({63'h0, exitEvent}, 64'h1, "first of pair");
        @(posedge clock);
        accReq.valid <= 1'b0;
        #1;
        check({63'h0, exitEvent}, 64'h1, "second of pair");
        chk_rec(vie_pkg::UNACCELERATED_ACCESS_EXIT_CODE, {31'h0, 1'b1, 20'h0, 8'h3F, 4'h0},
            64'h0, 1'b0);
        sts(2'h3);
        // Disabled block ignores failures
        wr(vie_pkg::REG_CONTROL, 32'h0, 4'h1);
        run_ipi(8'h0E, 8'h01, 10'h001, 1'b0, 32'h0, 8'h00);
        rd(vie_pkg::REG_STATUS, 32'h0, "disabled status");
        wr(vie_pkg::REG_CONTROL, 32'h1, 4'h1);
        rd(vie_pkg::REG_CONTROL, 32'h1, "control back");
        stop_test();
    end
endmodule

/* File: bench/vie_hv_model.sv */
`timescale 1ns/10ps
// Hypervisor-side software model: reaches the exit record over classic Wishbone
module vie_hv_model (
    input wire logic clock, // Core clock
    input wire logic [31:0] wbDatR, // Read data from the block
    input wire logic wbAck, // Acknowledge from the block
    output logic wbCyc, // Bus cycle
    output logic wbStb, // Strobe
    output logic wbWe, // Write enable
    output logic [7:0] wbAdr, // Byte address
    output logic [3:0] wbSel, // Byte selects
    output logic [31:0] wbDatW // Write data
);
    // Idle bus at time zero
    initial
    begin
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = 8'h00;
        wbSel = 4'h0;
        wbDatW = 32'h0;
    end

    // One classic cycle; request held until ack is sampled high
    task automatic bus_cycle(input logic we, input logic [7:0] adr, input logic [3:0] sel,
        input logic [31:0] dat, output logic [31:0] rdata);
        @(posedge clock);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= sel;
        wbDatW <= dat;
        @(posedge clock);
        // No limit here; the bench watchdog ends a hung cycle
        while (wbAck !== 1'b1)
        begin
            @(posedge clock);
        end
        rdata = wbDatR;
        // Released address, selects and data show the inverse, so nobody can lean on stale values
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        wbAdr <= ~adr;
        wbSel <= ~sel;
        wbDatW <= ~dat;
    endtask
endmodule

/* File: design/vie_cause_classifier.sv */
`timescale 1ns/10ps
// Decides whether an IPI attempt failed and why
module vie_cause_classifier (
    input wire vie_pkg::vie_ipi_req_type ipiReq, // Sampled IPI attempt
    output vie_pkg::vie_cause_type cause // Failure verdict
);
    logic badTarget;
    logic [7:0] tableIndex;

    // Shorthand and broadcast always index the physical table
    always_comb
    begin
        tableIndex = ipiReq.physIndex;
        if (!ipiReq.broadcast && ipiReq.logicalMode)
        begin
            tableIndex = ipiReq.logIndex;
        end
    end

    // Broadcast skips invalid physical entries, so only directed ones fail
    always_comb
    begin
        badTarget = 1'b0;
        if (!ipiReq.broadcast && ipiReq.logicalMode)
        begin
            badTarget = (ipiReq.cluster > vie_pkg::MAX_CLUSTER)
                || !ipiReq.logEntryValid;
        end
        else if (!ipiReq.broadcast)
        begin
            badTarget = (ipiReq.target > vie_pkg::MAX_PHYSICAL)
                || !ipiReq.physEntryValid;
        end
    end

    // Type faults first, then lookup, then backing page, then scheduling
    always_comb
    begin
        cause.fail = 1'b1;
        cause.code = vie_pkg::CAUSE_BAD_TYPE;
        cause.index = 8'h00;
        if (ipiReq.levelTrigger || ipiReq.destUnsupported)
        begin
            cause.code = vie_pkg::CAUSE_BAD_TYPE;
        end
        else if (badTarget)
        begin
            cause.code = vie_pkg::CAUSE_BAD_TARGET;
            cause.index = tableIndex;
        end
        else if (!ipiReq.backingValid)
        begin
            cause.code = vie_pkg::CAUSE_BAD_BACKING;
            cause.index = tableIndex;
        end
        else if (!ipiReq.onCore)
        begin
            cause.code = vie_pkg::CAUSE_NOT_RUNNING;
            cause.index = tableIndex;
        end
        else
        begin
            cause.fail = 1'b0;
        end
    end
endmodule

/* File: design/vie_exit_reporter.sv */
`timescale 1ns/10ps
module vie_exit_reporter (
    input wire logic clock, // Core clock, 25 MHz
    input wire logic sys_rst, // Async reset, active high
    input wire vie_pkg::vie_ipi_req_type ipiReq, // IPI attempt, one cycle
    input wire vie_pkg::vie_acc_req_type accReq, // Guest register access, one cycle
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [7:0] wb_adr_i, // Wishbone byte address
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    output logic irq, // Level interrupt
    output logic exitEvent, // Pulse: new exit record
    output vie_pkg::vie_exit_record_type exitRecord // Latest exit record
);
    vie_pkg::vie_cause_type ipiCause;
    logic [vie_pkg::STATUS_WIDTH-1:0] status;
    logic [vie_pkg::STATUS_WIDTH-1:0] mask;
    logic [vie_pkg::STATUS_WIDTH-1:0] statusSet;
    logic [vie_pkg::STATUS_WIDTH-1:0] statusClear;
    logic enable;
    logic ipiTake;
    logic accExitCond;
    logic accTake;
    logic completionWrite;
    logic wbHit;
    logic wbWrite;
    logic [31:0] next_readData;
    vie_pkg::vie_exit_record_type next_record;

    vie_cause_classifier classifier (
        .ipiReq(ipiReq),
        .cause(ipiCause)
    );

    // Event decode; an IPI exit wins a same-cycle clash with an access exit
    assign completionWrite = accReq.write
        && (accReq.offset == vie_pkg::COMPLETION_OFFSET);
    assign accExitCond = accReq.valid && (!accReq.accelerated
        || (completionWrite && accReq.eoiLevel));
    assign ipiTake = enable && ipiReq.valid && ipiCause.fail;
    assign accTake = enable && accExitCond && !ipiTake;

    // Build the whole record before it is stored
    always_comb
    begin
        next_record = exitRecord;
        if (ipiTake)
        begin
            next_record.code = vie_pkg::IPI_INCOMPLETE_EXIT_CODE;
            next_record.first = {ipiReq.cmdHigh, ipiReq.cmdLow};
            next_record.second = {ipiCause.code, 24'h000000,
                ipiCause.index};
        end
        else if (accTake)
        begin
            next_record.code = vie_pkg::UNACCELERATED_ACCESS_EXIT_CODE;
            next_record.first = 64'h0000000000000000;
            next_record.first[vie_pkg::RW_BIT] = accReq.write;
            next_record.first[vie_pkg::OFFSET_MSB:vie_pkg::OFFSET_LSB] =
                accReq.offset[vie_pkg::OFFSET_MSB:vie_pkg::OFFSET_LSB];
            next_record.second = 64'h0000000000000000;
            if (completionWrite)
            begin
                next_record.second[7:0] = accReq.vector;
            end
        end
    end

    // One edge writes code and both words, so no torn record is visible
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            exitRecord <= '0;
            exitEvent <= 1'b0;
        end
        else
        begin
            exitRecord <= next_record;
            exitEvent <= ipiTake || accTake;
        end
    end

    // Wishbone single-cycle slave, answers one cycle after the strobe
    assign wbHit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // Writes land on the ack edge, where the master still holds its data
    assign wbWrite = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= wbHit;
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        next_readData = 32'h00000000;
        if (wb_adr_i == vie_pkg::REG_FIRST_LO)
        begin
            next_readData = exitRecord.first[31:0];
        end
        else if (wb_adr_i == vie_pkg::REG_FIRST_HI)
        begin
            next_readData = exitRecord.first[63:32];
        end
        else if (wb_adr_i == vie_pkg::REG_SECOND_LO)
        begin
            next_readData = exitRecord.second[31:0];
        end
        else if (wb_adr_i == vie_pkg::REG_SECOND_HI)
        begin
            next_readData = exitRecord.second[63:32];
        end
        else if (wb_adr_i == vie_pkg::REG_EXIT_CODE)
        begin
            next_readData = exitRecord.code;
        end
        else if (wb_adr_i == vie_pkg::REG_STATUS)
        begin
            next_readData[vie_pkg::STATUS_WIDTH-1:0] = status;
        end
        else if (wb_adr_i == vie_pkg::REG_MASK)
        begin
            next_readData[vie_pkg::STATUS_WIDTH-1:0] = mask;
        end
        else if (wb_adr_i == vie_pkg::REG_CONTROL)
        begin
            next_readData[vie_pkg::CTRL_ENABLE] = enable;
        end
    end

    // Read data is sampled with the strobe so it lines up with ack
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wb_dat_o <= 32'h00000000;
        end
        else if (wbHit && !wb_we_i)
        begin
            wb_dat_o <= next_readData;
        end
    end

    // Mask and enable, low byte lane only
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mask <= vie_pkg::MASK_RESET;
            enable <= vie_pkg::CTRL_RESET;
        end
        else if (wbWrite && wb_adr_i == vie_pkg::REG_MASK)
        begin
            mask <= wb_dat_i[vie_pkg::STATUS_WIDTH-1:0];
        end
        else if (wbWrite && wb_adr_i == vie_pkg::REG_CONTROL)
        begin
            enable <= wb_dat_i[vie_pkg::CTRL_ENABLE];
        end
    end

    // Sticky events; a set in the clearing cycle survives
    assign statusSet = {accTake, ipiTake};
    assign statusClear = (wbWrite && wb_adr_i == vie_pkg::REG_STATUS)
        ? wb_dat_i[vie_pkg::STATUS_WIDTH-1:0] : '0;

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            status <= '0;
        end
        else
        begin
            status <= (status & ~statusClear) | statusSet;
        end
    end

    // Registered so irq rises one cycle after the status bit
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(status & mask);
        end
    end

    // Checks
    logic typeOk;
    logic targetOk;
    assign typeOk = !ipiReq.levelTrigger && !ipiReq.destUnsupported;
    assign targetOk = ipiReq.broadcast || (ipiReq.logicalMode
        ? (ipiReq.cluster <= vie_pkg::MAX_CLUSTER && ipiReq.logEntryValid)
        : (ipiReq.target <= vie_pkg::MAX_PHYSICAL && ipiReq.physEntryValid));

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    sequence ipiLive;
        enable && ipiReq.valid;
    endsequence
    sequence cleanIpi;
        ipiLive and (typeOk && targetOk && ipiReq.backingValid);
    endsequence
    sequence ipiExitOut;
        exitEvent && exitRecord.code == vie_pkg::IPI_INCOMPLETE_EXIT_CODE;
    endsequence

    // IPI exit: code, command copy and the cause layout
    ipi_exit_code_a: assert property (ipiTake |=> ipiExitOut)
        else $error("IPI failure gave no incomplete-IPI exit");

    ipi_cmd_copy_a: assert property (ipiTake |=> exitRecord.first
        == {$past(ipiReq.cmdHigh), $past(ipiReq.cmdLow)})
        else $error("Command copy wrong in first detail word");

    cause_field_a: assert property (ipiTake |=> exitRecord.second[63:32]
        <= vie_pkg::CAUSE_MAX && exitRecord.second[31:8] == 24'h000000)
        else $error("Cause field out of range or reserved bits set");

    // Expected index from the mode bits alone, not from the classifier
    logic [7:0] modeIndex;
    assign modeIndex = (ipiReq.broadcast || !ipiReq.logicalMode)
        ? ipiReq.physIndex : ipiReq.logIndex;

    // One property per cause, in priority order, plus a logical-entry check and a no-exit check
    bad_type_a: assert property (ipiLive and !typeOk
        |=> ipiExitOut and (exitRecord.second == 64'h0000000000000000))
        else $error("Level or unsupported IPI not cause 0");

    bad_target_a: assert property (ipiLive and (typeOk && !targetOk)
        |=> exitRecord.second[63:32] == vie_pkg::CAUSE_BAD_TARGET
        && exitRecord.second[7:0] == $past(modeIndex))
        else $error("Invalid target not cause 2");

    log_invalid_a: assert property (ipiLive and (typeOk && !ipiReq.broadcast
        && ipiReq.logicalMode && !ipiReq.logEntryValid) |=> ipiExitOut)
        else $error("Invalid logical entry gave no exit");

    bad_backing_a: assert property (ipiLive and (typeOk && targetOk
        && !ipiReq.backingValid) |=> exitRecord.second[63:32]
        == vie_pkg::CAUSE_BAD_BACKING && exitRecord.second[7:0] == $past(modeIndex))
        else $error("Bad backing page misreported");

    not_running_a: assert property (cleanIpi and !ipiReq.onCore
        |=> ipiExitOut and (exitRecord.second[63:32] == vie_pkg::CAUSE_NOT_RUNNING
        && exitRecord.second[7:0] == $past(modeIndex)))
        else $error("Not-running target misreported");

    all_running_a: assert property (cleanIpi and ipiReq.onCore
        |=> !(exitEvent && exitRecord.code == vie_pkg::IPI_INCOMPLETE_EXIT_CODE))
        else $error("Exit raised although every target runs");

    // Unaccelerated access exit and its detail words
    noaccel_exit_a: assert property (accTake |=> exitEvent
        && exitRecord.code == vie_pkg::UNACCELERATED_ACCESS_EXIT_CODE)
        else $error("Unaccelerated access gave no exit");

    eoi_level_a: assert property (enable && accReq.valid && accReq.accelerated
        && completionWrite && accReq.eoiLevel && !ipiTake |=> exitEvent)
        else $error("Level completion write gave no exit");

    rw_offset_a: assert property (accTake |=> exitRecord.first
        == {31'h00000000, $past(accReq.write), 20'h00000,
        $past(accReq.offset[11:4]), 4'h0})
        else $error("Access info word wrong");

    eoi_vector_a: assert property (accTake && completionWrite
        |=> exitRecord.second[7:0] == $past(accReq.vector))
        else $error("Completion vector missing");

    // Accelerated traffic must stay inside the guest
    logic accQuiet;
    assign accQuiet = accReq.valid && accReq.accelerated
        && !(completionWrite && accReq.eoiLevel) && !ipiReq.valid;
    accel_quiet_a: assert property (accQuiet |=> !exitEvent)
        else $error("Accelerated access raised an exit");

    // The record moves only with an exit, and all of it at once
    record_hold_a: assert property (!(ipiTake || accTake) |=> !exitEvent
        && $stable(exitRecord))
        else $error("Record changed without an exit");

    ipi_wins_a: assert property (ipiTake && accExitCond
        |=> exitRecord.code == vie_pkg::IPI_INCOMPLETE_EXIT_CODE)
        else $error("Access exit beat an IPI exit");

    record_atomic_a: assert property (exitEvent |-> ((exitRecord.code
        == vie_pkg::IPI_INCOMPLETE_EXIT_CODE) ? status[vie_pkg::ST_IPI]
        : status[vie_pkg::ST_NOACCEL]))
        else $error("Exit record and status out of step");

    // Bus handshake: one ack per request, one cycle long
    sequence wbRequest;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    ack_follows_a: assert property (wbRequest |=> wb_ack_o)
        else $error("Bus request not acknowledged");

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("Acknowledge longer than one cycle");

    // Status sticky until cleared; irq one cycle behind it
    logic irqCond;
    logic [vie_pkg::STATUS_WIDTH-1:0] statusKeep;
    assign irqCond = |(status & mask);
    assign statusKeep = status & ~statusClear;
    irq_level_a: assert property (1'b1 |-> irq == $past(irqCond))
        else $error("Interrupt out of step with status and mask");

    status_sticky_a: assert property (1'b1 |=> (status & $past(statusKeep))
        == $past(statusKeep))
        else $error("Status bit lost without a clear");

    ipi_status_a: assert property (ipiTake |=> status[vie_pkg::ST_IPI])
        else $error("IPI exit left no status bit");

    acc_status_a: assert property (accTake |=> status[vie_pkg::ST_NOACCEL])
        else $error("Access exit left no status bit");

    disabled_quiet_a: assert property (!enable |=> !exitEvent)
        else $error("Exit raised while disabled");
endmodule

/* File: design/vie_pkg.sv */
package vie_pkg;
    // Exit codes handed to the hypervisor; values are arbitrary
    localparam logic [31:0] IPI_INCOMPLETE_EXIT_CODE = 32'h0000_0401;
    localparam logic [31:0] UNACCELERATED_ACCESS_EXIT_CODE = 32'h0000_0402;
    // Failure cause codes of the second detail word
    localparam logic [31:0] CAUSE_BAD_TYPE = 32'h0000_0000;
    localparam logic [31:0] CAUSE_NOT_RUNNING = 32'h0000_0001;
    localparam logic [31:0] CAUSE_BAD_TARGET = 32'h0000_0002;
    localparam logic [31:0] CAUSE_BAD_BACKING = 32'h0000_0003;
    localparam logic [31:0] CAUSE_MAX = 32'h0000_0003;
    // Target limits
    localparam logic [7:0] MAX_CLUSTER = 8'h40;
    localparam logic [9:0] MAX_PHYSICAL = 10'h200;
    // Completion register offset and access info field positions
    localparam logic [11:0] COMPLETION_OFFSET = 12'h0B0;
    localparam int RW_BIT = 32;
    localparam int OFFSET_LSB = 4;
    localparam int OFFSET_MSB = 11;
    // Wishbone byte offsets
    localparam logic [7:0] REG_FIRST_LO = 8'h00;
    localparam logic [7:0] REG_FIRST_HI = 8'h04;
    localparam logic [7:0] REG_SECOND_LO = 8'h08;
    localparam logic [7:0] REG_SECOND_HI = 8'h0C;
    localparam logic [7:0] REG_EXIT_CODE = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_MASK = 8'h18;
    localparam logic [7:0] REG_CONTROL = 8'h1C;
    // Status, mask and control layout
    localparam int ST_IPI = 0;
    localparam int ST_NOACCEL = 1;
    localparam int STATUS_WIDTH = 2;
    localparam int CTRL_ENABLE = 0;
    localparam logic [STATUS_WIDTH-1:0] MASK_RESET = 2'h0;
    localparam logic CTRL_RESET = 1'b1;

    typedef struct packed {
        logic valid;
        logic [31:0] cmdHigh;
        logic [31:0] cmdLow;
        logic levelTrigger;
        logic destUnsupported;
        logic broadcast;
        logic logicalMode;
        logic [7:0] cluster;
        logic [9:0] target;
        logic logEntryValid;
        logic physEntryValid;
        logic backingValid;
        logic onCore;
        logic [7:0] logIndex;
        logic [7:0] physIndex;
    } vie_ipi_req_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] offset;
        logic accelerated;
        logic eoiLevel;
        logic [7:0] vector;
    } vie_acc_req_type;

    typedef struct packed {
        logic fail;
        logic [31:0] code;
        logic [7:0] index;
    } vie_cause_type;

    typedef struct packed {
        logic [31:0] code;
        logic [63:0] first;
        logic [63:0] second;
    } vie_exit_record_type;
endpackage
